// file: rtl/e1sc_consts.svh
// Offsets, reset values and frame constants of the receive spare-bit capture block
`ifndef E1SC_CONSTS_SVH
`define E1SC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses (paddr[11:0])
// ----------------------------------------------------------------------
`define E1SC_ADDR_CTRL      12'h10c
`define E1SC_ADDR_CAP5      12'h140
`define E1SC_ADDR_CAP6      12'h144
`define E1SC_ADDR_CAP7      12'h148
`define E1SC_ADDR_CAP8      12'h14c
`define E1SC_ADDR_STAT      12'h150

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define E1SC_CTRL_RESET     4'h0
`define E1SC_ARMED_RESET    4'h0
`define E1SC_CAP_RESET      8'h00
`define E1SC_GOT_RESET      8'h00
`define E1SC_COUNT_RESET    8'h00
`define E1SC_RDATA_RESET    32'h0000_0000
`define E1SC_CTRL_MSB       3
`define E1SC_CTRL_LSB       0
`define E1SC_CTRL_PAD       28'h000_0000
`define E1SC_CAP_PAD        24'h00_0000
`define E1SC_STAT_PAD_HI    16'h0000
`define E1SC_STAT_PAD_LO    7'h00
`define E1SC_COUNT_STEP     8'h01

// ----------------------------------------------------------------------
// Multiframe positions (index i stands for frame i+1)
// ----------------------------------------------------------------------
`define E1SC_FIRST_FRAME    4'h0
`define E1SC_LAST_FRAME     4'hf
`define E1SC_GOT_FULL       7'h7f

`endif

// file: rtl/e1sc_pkg.sv
// Types shared by the receive spare-bit capture block
package e1sc_pkg;

    // One timeslot-0 report from the receive framer per frame
    typedef struct packed {
        logic       valid;      // One-cycle pulse per received frame
        logic       mf_locked;  // CRC-4 multiframe alignment held
        logic [3:0] frame_idx;  // 0..15 for frames 1..16
        logic [3:0] sa;         // [0]=Sa5 .. [3]=Sa8 of this frame
    } e1sc_rx_frame_t;

    typedef struct packed {
        logic [7:0] collect;
        logic [7:0] capture;
    } e1sc_lane_state_t;

    typedef struct packed {
        logic [3:0]  enable;
        logic [3:0]  armed;
        logic [7:0]  got;
        logic [7:0]  mf_count;
        logic [31:0] prdata;
        logic        pslverr;
    } e1sc_top_state_t;

endpackage

// file: rtl/e1sc_spare_lane.sv
// Collects one spare bit over a multiframe and holds its capture register
`timescale 1ns/100ps
`default_nettype none
`include "e1sc_consts.svh"

module e1sc_spare_lane (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enable,
    input  wire logic       sample,
    input  wire logic [2:0] bit_pos,
    input  wire logic       sa_bit,
    input  wire logic       commit,
    output logic      [7:0] capture
);
    import e1sc_pkg::*;

    e1sc_lane_state_t s_r;
    e1sc_lane_state_t s_nxt;
    logic [7:0]       merged;

    // ------------------------------------------------------------------
    // Collection and commit
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt  = s_r;
        merged = s_r.collect;
        if (sample) begin
            merged[bit_pos] = sa_bit;
        end
        if (!enable) begin
            // Disabled lanes show zero rather than stale data
            s_nxt.collect = `E1SC_CAP_RESET;
            s_nxt.capture = `E1SC_CAP_RESET;
        end else begin
            s_nxt.collect = merged;
            if (commit) begin
                // Frame 16 bit is merged in the same cycle it arrives
                s_nxt.capture = merged;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.collect <= `E1SC_CAP_RESET;
            s_r.capture <= `E1SC_CAP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign capture = s_r.capture;

endmodule
`default_nettype wire

// file: rtl/e1sc_top.sv
// E1 receive spare-bit (Sa5..Sa8) capture block with APB register access
//
// What this block does
// - Each capture register holds its spare bit from the latest whole multiframe it was enabled for from frame 1.
// - Registers update only after a whole multiframe, all eight bits together.
// - A capture register shows received values only while its enable is 1.
// - Register bit 7 holds the spare bit of frame 2.
// - Bit 6 holds frame 4; each lower bit takes the next even frame.
// - Four read-only 8-bit capture registers, Sa5 to Sa8, reset to zero.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "e1sc_consts.svh"

module e1sc_top (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire e1sc_pkg::e1sc_rx_frame_t rx_frame
);
    import e1sc_pkg::*;

    // ------------------------------------------------------------------
    // State and decode signals
    // ------------------------------------------------------------------
    e1sc_top_state_t s_r;
    e1sc_top_state_t s_nxt;

    logic       apb_setup;
    logic       apb_access;
    logic       ctrl_write;
    logic [31:0] rd_word;
    logic       addr_hit;
    logic       frame_odd;
    logic       sample;
    logic       commit;
    logic [2:0] bit_pos;
    logic [7:0] cap [4];
    logic [7:0] cap_view [4];
    logic       first_frame;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // Read data and error are latched in the setup cycle, so every
    // access completes with no wait state and prdata comes from a flop.
    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign ctrl_write = apb_access && pwrite && (paddr == `E1SC_ADDR_CTRL);

    // ------------------------------------------------------------------
    // Multiframe position
    // ------------------------------------------------------------------
    // Frames 2,4..16 sit at odd indices; bit 7 down to bit 0 in turn.
    assign frame_odd = rx_frame.frame_idx[0];
    assign bit_pos   = ~rx_frame.frame_idx[3:1];
    assign sample    = rx_frame.valid && rx_frame.mf_locked && frame_odd;

    // A capture needs all seven earlier even frames plus frame 16 now;
    // a multiframe broken by loss of alignment is dropped whole.
    assign commit = rx_frame.valid && rx_frame.mf_locked
                    && (rx_frame.frame_idx == `E1SC_LAST_FRAME)
                    && (s_r.got[7:1] == `E1SC_GOT_FULL);

    // Frame 1 of a multiframe arms every lane that is enabled by then
    assign first_frame = rx_frame.valid && rx_frame.mf_locked
                         && (rx_frame.frame_idx == `E1SC_FIRST_FRAME);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_word  = `E1SC_RDATA_RESET;
        addr_hit = 1'b1;
        unique case (paddr)
            `E1SC_ADDR_CTRL: begin
                rd_word = {`E1SC_CTRL_PAD, s_r.enable};
            end
            `E1SC_ADDR_CAP5: begin
                rd_word = {`E1SC_CAP_PAD, cap_view[0]};
            end
            `E1SC_ADDR_CAP6: begin
                rd_word = {`E1SC_CAP_PAD, cap_view[1]};
            end
            `E1SC_ADDR_CAP7: begin
                rd_word = {`E1SC_CAP_PAD, cap_view[2]};
            end
            `E1SC_ADDR_CAP8: begin
                rd_word = {`E1SC_CAP_PAD, cap_view[3]};
            end
            `E1SC_ADDR_STAT: begin
                rd_word = {`E1SC_STAT_PAD_HI, s_r.mf_count,
                           `E1SC_STAT_PAD_LO, rx_frame.mf_locked};
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Bus answer for the coming access phase
        if (apb_setup) begin
            s_nxt.prdata  = pwrite ? `E1SC_RDATA_RESET : rd_word;
            s_nxt.pslverr = !addr_hit;
        end

        // Writes to capture registers are ignored: they are read-only
        if (ctrl_write) begin
            s_nxt.enable = pwdata[`E1SC_CTRL_MSB:`E1SC_CTRL_LSB];
        end

        // A lane enabled in mid-multiframe has missed some even frames,
        // so it may commit only once it has been enabled since frame 1
        for (int g = 0; g < 4; g++) begin
            if (!s_r.enable[g]) begin
                s_nxt.armed[g] = 1'b0;
            end else if (first_frame) begin
                s_nxt.armed[g] = 1'b1;
            end
        end

        // Track which even frames of this multiframe have been seen
        if (!rx_frame.mf_locked) begin
            s_nxt.got = `E1SC_GOT_RESET;
        end else if (rx_frame.valid) begin
            if (rx_frame.frame_idx == `E1SC_FIRST_FRAME) begin
                s_nxt.got = `E1SC_GOT_RESET;
            end else if (frame_odd) begin
                s_nxt.got[bit_pos] = 1'b1;
            end
        end
        if (commit) begin
            s_nxt.got      = `E1SC_GOT_RESET;
            s_nxt.mf_count = s_r.mf_count + `E1SC_COUNT_STEP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.enable   <= `E1SC_CTRL_RESET;
            s_r.got      <= `E1SC_GOT_RESET;
            s_r.mf_count <= `E1SC_COUNT_RESET;
            s_r.armed    <= `E1SC_ARMED_RESET;
            s_r.prdata   <= `E1SC_RDATA_RESET;
            s_r.pslverr  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // One lane per spare bit, Sa5..Sa8
    // ------------------------------------------------------------------
    // This block serves one framer channel; each channel instantiates
    // its own copy, so the four registers are never shared.
    for (genvar g = 0; g < 4; g++) begin : g_lane
        e1sc_spare_lane u_lane (
            .pclk    (pclk),
            .presetn (presetn),
            .enable  (s_r.enable[g]),
            .sample  (sample),
            .bit_pos (bit_pos),
            .sa_bit  (rx_frame.sa[g]),
            .commit  (commit && s_r.armed[g]),
            .capture (cap[g])
        );
        // A disabled lane reads zero at once, not one cycle later
        assign cap_view[g] = s_r.enable[g] ? cap[g] : `E1SC_CAP_RESET;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata  = s_r.prdata;
    assign pslverr = s_r.pslverr && apb_access;
    assign pready  = apb_access;

endmodule
`default_nettype wire

// file: tb/e1sc_top_sva.sv
// Port-level assertion checker for the spare-bit capture block
`timescale 1ns/100ps
`default_nettype none
module e1sc_top_chk (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire e1sc_pkg::e1sc_rx_frame_t rx_frame
);
    import e1sc_pkg::*;
    logic       acc, rd_cap, commit, ctrl_wr, mapped, chg_r;
    logic [3:0] en_sh, quiet_r;
    logic [7:0] last_r [4];
    assign acc = psel && penable;
    assign mapped = paddr inside {12'h10c, 12'h140, 12'h144, 12'h148, 12'h14c, 12'h150};
    assign rd_cap = acc && !pwrite && paddr[11:4] == 8'h14 && paddr[1:0] == 2'b00;
    assign ctrl_wr = acc && pwrite && paddr == 12'h10c;
    assign commit = rx_frame.valid && rx_frame.mf_locked && rx_frame.frame_idx == 4'hf;
    // Remember the last capture read; only a commit or a control write may change it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sh <= 4'h0;
            chg_r <= 1'b0;
            quiet_r <= 4'hf;
            last_r <= '{default: 8'h00};
        end else begin
            if (rd_cap) begin
                // Read data is latched at setup, so a change at that edge is not in it
                quiet_r[paddr[3:2]] <= !chg_r;
                last_r[paddr[3:2]] <= prdata[7:0];
            end
            if (commit || ctrl_wr)
                quiet_r <= 4'h0;
            if (ctrl_wr)
                en_sh <= pwdata[3:0];
            chg_r <= commit || ctrl_wr;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_access: assert property (pready == acc)
        else $error("pready does not follow the access phase");
    chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access answered with error");
    chk_cap_upper: assert property (rd_cap |-> prdata[31:8] == 24'h00_0000)
        else $error("capture read has upper bits set");
    chk_cap_disabled: assert property (rd_cap && !en_sh[paddr[3:2]] |-> prdata[7:0] == 8'h00)
        else $error("disabled capture not zero");
    chk_cap_held: assert property (rd_cap && quiet_r[paddr[3:2]] |-> prdata[7:0] == last_r[paddr[3:2]])
        else $error("capture changed without a full multiframe");
    chk_ctrl_read: assert property (acc && !pwrite && paddr == 12'h10c |-> prdata == {28'h000_0000, en_sh})
        else $error("enable register readback wrong");
    cover property (commit);
    cover property (rd_cap && en_sh == 4'hf);
    cover property (acc && pslverr);
endmodule
bind e1sc_top e1sc_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_frame);
`default_nettype wire

// file: tb/e1sc_remote_term.sv
// Far-end E1 terminal model sending CRC-4 multiframe reports
`timescale 1ns/100ps
`default_nettype none
module e1sc_remote_term (
    input  wire logic                    pclk,
    output var e1sc_pkg::e1sc_rx_frame_t rx_frame
);
    import e1sc_pkg::*;
    initial rx_frame = '{1'b0, 1'b1, 4'h0, 4'h0};
    // V is {Sa8, Sa7, Sa6, Sa5}; sends frame indices first..first+nfr-1, so a short
    // run leaves the multiframe unfinished
    task automatic send_mf(input logic [31:0] v, input int first, input int nfr);
        logic [3:0] b;
        for (int i = first; i < first + nfr; i++) begin
            for (int k = 0; k < 4; k++)
                b[k] = v[8*k + 7 - i/2];
            @(posedge pclk);
            // Odd frames carry the inverse so a wrong frame mapping shows
            rx_frame <= '{1'b1, 1'b1, 4'(i), i[0] ? b : ~b};
            @(posedge pclk);
            rx_frame <= '{1'b0, 1'b1, ~4'(i), ~rx_frame.sa};
        end
    endtask
    // Alignment lost for one cycle between two frames
    task automatic drop_lock;
        @(posedge pclk);
        rx_frame.mf_locked <= 1'b0;
        @(posedge pclk);
        rx_frame.mf_locked <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: tb/test_e1_rx_spare_bit_capture.sv
// Self-checking bench for the spare-bit capture block
`timescale 1ns/100ps
`default_nettype none
module test_e1_rx_spare_bit_capture;
    import e1sc_pkg::*;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    e1sc_rx_frame_t rx_frame;
    int             n_mismatch = 0;
    int             n_checks = 0;
    e1sc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_frame);
    e1sc_remote_term mdl_u (.pclk, .rx_frame);
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic e, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check({err, rd}, {e, exp});
    endtask
    task automatic rd_caps(input logic [31:0] v);
        for (int k = 0; k < 4; k++)
            rd_chk(12'h140 + 12'(4*k), 1'b0, {24'h00_0000, v[8*k +: 8]});
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_caps(32'h0000_0000);
        xfer(1'b1, 12'h140, 32'h0000_00ff);
        rd_chk(12'h140, 1'b0, 32'h0000_0000);
        rd_chk(12'h200, 1'b1, 32'h0000_0000);
        xfer(1'b1, 12'h10c, 32'h0000_000f);
        rd_chk(12'h10c, 1'b0, 32'h0000_000f);
        mdl_u.send_mf(32'h810f_3ca5, 0, 16);
        // An unfinished multiframe must leave the registers alone
        mdl_u.send_mf(32'h5ac3_f07e, 0, 15);
        xfer(1'b1, 12'h144, 32'h0000_0000);
        rd_caps(32'h810f_3ca5);
        mdl_u.send_mf(32'h5ac3_f07e, 0, 16);
        rd_caps(32'h5ac3_f07e);
        xfer(1'b1, 12'h10c, 32'h0000_0005);
        mdl_u.send_mf(32'h7e96_18e7, 0, 16);
        rd_caps(32'h0096_00e7);
        // Lanes switched on in mid-multiframe wait for the next whole one
        mdl_u.send_mf(32'h3c5a_a5c3, 0, 8);
        xfer(1'b1, 12'h10c, 32'h0000_000f);
        mdl_u.send_mf(32'h3c5a_a5c3, 8, 8);
        rd_caps(32'h005a_00c3);
        // Loss of alignment in mid-multiframe discards it
        mdl_u.send_mf(32'hffff_ffff, 0, 8);
        mdl_u.drop_lock;
        mdl_u.send_mf(32'hffff_ffff, 8, 8);
        rd_caps(32'h005a_00c3);
        // Four whole multiframes committed, alignment held
        rd_chk(12'h150, 1'b0, 32'h0000_0401);
        give_verdict;
    end
    initial begin
        #(40 * 4000);
        n_mismatch++;
        give_verdict;
    end
endmodule
`default_nettype wire
